// *** verilog/bpis_pkg.sv ***
`default_nettype none
package bpis_pkg;
   // Register byte offsets
   localparam logic [6:0] OFS_CTRL = 7'h00;
   localparam logic [6:0] OFS_FMAX = 7'h04;
   localparam logic [6:0] OFS_LRV  = 7'h08;
   localparam logic [6:0] OFS_URV  = 7'h0c;
   localparam logic [6:0] OFS_DAMP = 7'h10;
   localparam logic [6:0] OFS_STAT = 7'h14;
   localparam logic [6:0] OFS_VAL  = 7'h18;
   localparam logic [6:0] OFS_FREQ = 7'h1c;
   localparam logic [6:0] OFS_TEXT = 7'h20;  // Name words 0x20..0x2c, unit words 0x30..0x3c

   // Control field positions
   localparam int CTRL_EN   = 0;
   localparam int CTRL_PFM  = 1;
   localparam int CTRL_POL  = 2;
   localparam int CTRL_DEC  = 4;
   localparam int CTRL_VAR  = 6;
   localparam int CTRL_UNIT = 8;

   // Values after reset and legal ranges (values in hundredths)
   localparam logic [31:0] CTRL_RST = 32'h0000_0025;
   localparam logic [16:0] FMAX_MIN = 17'h02710;
   localparam logic [16:0] FMAX_MAX = 17'h186a0;
   localparam logic [16:0] FMAX_RST = 17'h186a0;
   localparam logic [31:0] LRV_MIN  = 32'hfffc_f2c0;
   localparam logic [31:0] LRV_RST  = 32'h0000_0000;
   localparam logic [31:0] URV_MAX  = 32'h000f_4240;
   localparam logic [31:0] URV_RST  = 32'h0000_0000;
   localparam logic [5:0]  DAMP_MAX = 6'h3c;
   localparam logic [5:0]  DAMP_RST = 6'h00;

   // Input variable and flow unit codes
   localparam logic [1:0] VAR_FREQ  = 2'h0;
   localparam logic [1:0] VAR_PARAM = 2'h1;
   localparam logic [1:0] VAR_FLOW  = 2'h2;
   localparam logic [2:0] UNIT_LPS  = 3'h0;
   localparam logic [2:0] UNIT_MGD  = 3'h6;

   // Output format: value in hundredths times mul, divided by div
   localparam logic [6:0] FMT_DIV [0:3] = '{7'h64, 7'h0a, 7'h01, 7'h01};
   localparam logic [3:0] FMT_MUL [0:3] = '{4'h1, 4'h1, 4'h1, 4'ha};

   // Timing
   localparam logic [6:0] CENTI_PER_HZ    = 7'h64;
   localparam int unsigned GATE_TIME_MS    = 1000;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned GATE_CYCLES_DFLT = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [5:0]  DIV_STEPS       = 6'h34;
endpackage
`default_nettype wire

// *** verilog/bpis_meas_if.sv ***
`default_nettype none
interface bpis_meas_if;
   logic        run;     // Pulse measurement active
   logic [16:0] fmax;    // Full scale, centi-Hz
   logic        level;   // Filtered input level
   logic [16:0] sample;  // Rate of last gate, centi-Hz
   logic        stb;     // One cycle per finished gate
   modport ctl  (output run, fmax, input level, sample, stb);
   modport meas (input run, fmax, output level, sample, stb);
endinterface
`default_nettype wire

// *** verilog/bpis_freq_meas.sv ***
`default_nettype none
module bpis_freq_meas
   import bpis_pkg::*;
#(
   parameter int unsigned GATE_CYCLES = GATE_CYCLES_DFLT
) (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   sys_rst_i,
   // Field input
   input  wire logic   pulse_i,
   // Towards the channel logic
   bpis_meas_if.meas   m
);
   typedef struct packed {
      logic [2:0]  sync;
      logic        lvl;
      logic [23:0] gate;
      logic [10:0] cnt;
      logic [16:0] sample;
      logic        stb;
   } bpis_fm_s_t;

   bpis_fm_s_t r;
   bpis_fm_s_t next_r;
   logic [17:0] c100;

   // Three-stage synchroniser, gate counter and clamp
   always_comb begin
      next_r = r;
      c100 = '0;
      next_r.sync = {r.sync[1:0], pulse_i};
      if (r.sync[1] == r.sync[2]) begin
         next_r.lvl = r.sync[2];
      end
      next_r.stb = 1'b0;
      if (!m.run) begin
         next_r.gate = '0;
         next_r.cnt  = '0;
      end else begin
         // Rising edges counted; saturate so a runaway input cannot wrap
         if (next_r.lvl && !r.lvl && r.cnt != 11'h7ff) begin
            next_r.cnt = r.cnt + 11'h001;
         end
         // An edge in the last gate cycle still belongs to this gate, else it is lost
         if (r.gate == 24'(GATE_CYCLES - 1)) begin
            c100          = 18'(next_r.cnt) * 18'(CENTI_PER_HZ);
            next_r.gate   = '0;
            next_r.cnt    = '0;
            next_r.stb    = 1'b1;
            next_r.sample = (c100 > 18'(m.fmax)) ? m.fmax : c100[16:0];
         end else begin
            next_r.gate = r.gate + 24'h000001;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign m.level  = r.lvl;
   assign m.sample = r.sample;
   assign m.stb    = r.stb;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_CLAMP: assert property (r.stb |-> r.sample <= m.fmax)
      else $error("Sample above full scale");
   AST_STOP: assert property (!m.run |=> !r.stb ##1 !r.stb)
      else $error("Gate result while stopped");
endmodule // bpis_freq_meas
`default_nettype wire

// *** verilog/bpis_top.sv ***
// Added by the designer: the register addresses and the AHB-Lite slave port.
`default_nettype none
module bpis_top
   import bpis_pkg::*;
#(
   parameter int unsigned GATE_CYCLES = GATE_CYCLES_DFLT,
   parameter logic [7:0]  SLOT_NO     = 8'h01,
   parameter logic [7:0]  INPUT_NO    = 8'h01
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output var  logic [31:0] hrdata_o,
   output var  logic        hreadyout_o,
   output var  logic        hresp_o,
   // Field input
   input  wire logic        binary_in_i,
   // Channel results
   output var  logic        switch_state_o,
   output var  logic [31:0] value_o,
   output var  logic        value_valid_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_SUM, ST_PREP, ST_DIV, ST_OUT} bpis_st_t;

   typedef struct packed {
      logic [31:0]       ctrl;
      logic [16:0]       fmax;
      logic [31:0]       lrv;
      logic [31:0]       urv;
      logic [5:0]        damp;
      logic [7:0][31:0]  text;
      logic [59:0][16:0] ring;
      logic [5:0]        wp;
      logic [5:0]        rp;
      logic [5:0]        k;
      logic [22:0]       sum;
      logic [51:0]       quo;
      logic [32:0]       rem;
      logic [31:0]       den;
      logic              neg;
      logic [5:0]        step;
      bpis_st_t          st;
      logic [31:0]       value;
      logic              valid;
      logic              sw;
      logic [16:0]       freq;
      logic              act;
      logic              wr;
      logic              hit;
      logic [6:0]        addr;
      logic              ready;
      logic [31:0]       rdata;
   } bpis_top_s_t;

   localparam bpis_top_s_t TOP_RST = '{ctrl: CTRL_RST, fmax: FMAX_RST, lrv: LRV_RST,
                                       urv: URV_RST, damp: DAMP_RST, st: ST_IDLE,
                                       ready: 1'b1, default: '0};

   bpis_top_s_t r;
   bpis_top_s_t next_r;
   bpis_meas_if mi ();

   logic              en, pfm, pol;
   logic [1:0]        dec, var_sel;
   logic [5:0]        n_avg;
   logic [31:0]       rd_word;
   logic signed [51:0] w_lo, w_hi, w_num;
   logic [32:0]       rem_sh;
   logic [31:0]       w;

   // Configuration fields
   assign en      = r.ctrl[CTRL_EN];
   assign pfm     = r.ctrl[CTRL_PFM];
   assign pol     = r.ctrl[CTRL_POL];
   assign dec     = r.ctrl[CTRL_DEC +: 2];
   assign var_sel = r.ctrl[CTRL_VAR +: 2];
   assign n_avg   = (r.damp == 6'h00) ? 6'h01 : r.damp;
   assign w       = hwdata_i;

   assign mi.run  = en & pfm;
   assign mi.fmax = r.fmax;

   bpis_freq_meas #(
      .GATE_CYCLES (GATE_CYCLES)
   ) u_meas (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pulse_i   (binary_in_i),
      .m         (mi.meas)
   );

   // Read mux; unmapped words read as zero
   always_comb begin
      rd_word = '0;
      if (r.hit) begin
         if (r.addr[6:5] == 2'h1) begin
            rd_word = r.text[r.addr[4:2]];
         end else begin
            unique case (r.addr)
               OFS_CTRL: rd_word = r.ctrl;
               OFS_FMAX: rd_word = 32'(r.fmax);
               OFS_LRV:  rd_word = r.lrv;
               OFS_URV:  rd_word = r.urv;
               OFS_DAMP: rd_word = 32'(r.damp);
               OFS_STAT: rd_word = {8'h00, INPUT_NO, SLOT_NO, 6'h00, r.valid, r.sw};
               OFS_VAL:  rd_word = r.value;
               OFS_FREQ: rd_word = 32'(r.freq);
               default:  rd_word = '0;
            endcase
         end
      end
   end

   // Bus slave, register writes, static level and value pipeline
   always_comb begin
      next_r = r;
      w_lo   = '0;
      w_hi   = '0;
      w_num  = '0;
      rem_sh = '0;

      // One wait state per transfer keeps read data on a flop
      if (r.act) begin
         next_r.act   = 1'b0;
         next_r.ready = 1'b1;
         next_r.rdata = rd_word;
         if (r.wr && r.hit) begin
            if (r.addr[6:5] == 2'h1) begin
               next_r.text[r.addr[4:2]] = w;
            end else begin
               unique case (r.addr)
                  OFS_CTRL: begin
                     next_r.ctrl = '0;
                     next_r.ctrl[CTRL_EN]  = w[CTRL_EN];
                     next_r.ctrl[CTRL_PFM] = w[CTRL_PFM];
                     next_r.ctrl[CTRL_POL] = w[CTRL_POL];
                     next_r.ctrl[CTRL_DEC +: 2] = w[CTRL_DEC +: 2];
                     // Undefined codes fall back to the last legal one
                     next_r.ctrl[CTRL_VAR +: 2] = (w[CTRL_VAR +: 2] > VAR_FLOW) ?
                                                  VAR_FLOW : w[CTRL_VAR +: 2];
                     next_r.ctrl[CTRL_UNIT +: 3] = (w[CTRL_UNIT +: 3] > UNIT_MGD) ?
                                                   UNIT_MGD : w[CTRL_UNIT +: 3];
                  end
                  OFS_FMAX: begin
                     if (w < 32'(FMAX_MIN)) begin
                        next_r.fmax = FMAX_MIN;
                     end else if (w > 32'(FMAX_MAX)) begin
                        next_r.fmax = FMAX_MAX;
                     end else begin
                        next_r.fmax = w[16:0];
                     end
                  end
                  OFS_LRV: begin
                     if ($signed(w) < $signed(LRV_MIN)) begin
                        next_r.lrv = LRV_MIN;
                     end else if ($signed(w) > 0) begin
                        next_r.lrv = '0;
                     end else begin
                        next_r.lrv = w;
                     end
                  end
                  OFS_URV: begin
                     if ($signed(w) < 0) begin
                        next_r.urv = '0;
                     end else if (w > URV_MAX) begin
                        next_r.urv = URV_MAX;
                     end else begin
                        next_r.urv = w;
                     end
                  end
                  OFS_DAMP: next_r.damp = (w > 32'(DAMP_MAX)) ? DAMP_MAX : w[5:0];
                  default: ;
               endcase
            end
         end
      end else if (hsel_i && htrans_i[1] && hready_i) begin
         next_r.act   = 1'b1;
         next_r.ready = 1'b0;
         next_r.wr    = hwrite_i;
         next_r.hit   = (haddr_i[31:7] == 25'h0000000);
         next_r.addr  = {haddr_i[6:2], 2'b00};
      end

      // Switch position against chosen active level
      next_r.sw = en & ~pfm & (mi.level == pol);

      // Ring of gate samples, averaged, scaled and formatted by one divider
      unique case (r.st)
         ST_IDLE: begin
            if (mi.stb) begin
               next_r.ring[r.wp] = mi.sample;
               next_r.freq = mi.sample;
               next_r.rp   = r.wp;
               next_r.wp   = (r.wp == DAMP_MAX - 6'h01) ? 6'h00 : r.wp + 6'h01;
               next_r.k    = '0;
               next_r.sum  = '0;
               next_r.st   = ST_SUM;
            end
         end
         ST_SUM: begin
            // Walk back over the newest n samples
            next_r.sum = r.sum + 23'(r.ring[r.rp]);
            next_r.rp  = (r.rp == 6'h00) ? DAMP_MAX - 6'h01 : r.rp - 6'h01;
            next_r.k   = r.k + 6'h01;
            if (r.k == n_avg - 6'h01) begin
               next_r.st = ST_PREP;
            end
         end
         ST_PREP: begin
            // Frequency output is the same line from 0 to full scale
            if (var_sel == VAR_FREQ) begin
               w_hi = 52'(r.fmax);
            end else begin
               w_lo = {{20{r.lrv[31]}}, r.lrv};
               w_hi = {20'h00000, r.urv};
            end
            // (lo*fmax*n + (hi-lo)*sum) * mul / (fmax*n*div)
            w_num = (w_lo * $signed(52'(r.fmax)) * $signed(52'(n_avg)) +
                     (w_hi - w_lo) * $signed(52'(r.sum))) *
                    $signed(52'(FMT_MUL[dec]));
            next_r.neg  = w_num[51];
            next_r.quo  = w_num[51] ? 52'(-w_num) : 52'(w_num);
            next_r.den  = 32'(r.fmax) * 32'(n_avg) * 32'(FMT_DIV[dec]);
            next_r.rem  = '0;
            next_r.step = '0;
            next_r.st   = ST_DIV;
         end
         ST_DIV: begin
            // Restoring division, one quotient bit a cycle
            rem_sh = {r.rem[31:0], r.quo[51]};
            next_r.quo = {r.quo[50:0], 1'b0};
            if (rem_sh >= {1'b0, r.den}) begin
               next_r.rem    = rem_sh - {1'b0, r.den};
               next_r.quo[0] = 1'b1;
            end else begin
               next_r.rem = rem_sh;
            end
            next_r.step = r.step + 6'h01;
            if (r.step == DIV_STEPS - 6'h01) begin
               next_r.st = ST_OUT;
            end
         end
         ST_OUT: begin
            next_r.value = r.neg ? -r.quo[31:0] : r.quo[31:0];
            next_r.valid = 1'b1;
            next_r.st    = ST_IDLE;
         end
      endcase

      // Disabled or static channel forgets its history
      if (!mi.run) begin
         next_r.ring  = '0;
         next_r.wp    = '0;
         next_r.st    = ST_IDLE;
         next_r.value = '0;
         next_r.valid = 1'b0;
         next_r.freq  = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r <= TOP_RST;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from state
   assign hrdata_o       = r.rdata;
   assign hreadyout_o    = r.ready;
   assign hresp_o        = 1'b0;  // Always OKAY
   assign switch_state_o = r.sw;
   assign value_o        = r.value;
   assign value_valid_o  = r.valid;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_OFF_QUIET: assert property (!en |=> !r.sw && !r.valid)
      else $error("Disabled channel still reports");
   AST_STATIC_LEVEL: assert property (en && !pfm && mi.level == pol |=> r.sw)
      else $error("Active level not reported");
   AST_POL_INACTIVE: assert property (mi.level != pol |=> !r.sw)
      else $error("Inactive level reported active");
   AST_STATIC_NOVAL: assert property (!pfm |=> !r.valid)
      else $error("Value produced in static mode");
   AST_FMAX_RANGE: assert property (r.fmax >= FMAX_MIN && r.fmax <= FMAX_MAX)
      else $error("Full scale out of range");
   AST_LRV_RANGE: assert property ($signed(r.lrv) >= $signed(LRV_MIN)
                                   && $signed(r.lrv) <= 0)
      else $error("Lower range out of range");
   AST_URV_RANGE: assert property (r.urv <= URV_MAX)
      else $error("Upper range out of range");
   AST_DAMP_RANGE: assert property (r.damp <= DAMP_MAX)
      else $error("Damping out of range");
   // A disable during the computation clears the result; that is allowed
   AST_UPDATE: assert property (r.st == ST_IDLE && mi.stb && mi.run
                                |-> ##[55:120] ((r.valid && $past(r.st) == ST_OUT)
                                                || (r.st == ST_IDLE && !r.valid)))
      else $error("Value not updated after sample");
   // Format is fixed at the preparation step, so the check starts there
   AST_FREQ_2DEC: assert property (r.st == ST_PREP && var_sel == VAR_FREQ && dec == 2'h2
                                   && n_avg == 6'h01 && mi.run
                                   |-> ##54 (r.value == 32'(r.freq) || !r.valid))
      else $error("Frequency format wrong");
   AST_BUS_WAIT: assert property (r.act |-> !r.ready ##1 r.ready)
      else $error("Wait state length wrong");
endmodule // bpis_top
`default_nettype wire

// *** tb/bpis_pulse_src.sv ***
`default_nettype none
// Field-side source: a switch level when idle, a square pulse train when running
module bpis_pulse_src (
   // Clock
   input  wire logic       clk_i,
   // Source control
   input  wire logic       run_i,
   input  wire logic       level_i,
   input  wire logic [7:0] half_i,
   // Driven line
   output var  logic       pulse_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;

   initial begin
      cnt     = 8'h00;
      pulse_o = 1'b0;
   end

   // Toggle every half_i cycles; a gate that is a multiple of the period sees a fixed count
   always @(posedge clk_i) begin
      if (!run_i) begin
         cnt     <= 8'h00;
         pulse_o <= level_i;
      end else if (cnt >= half_i - 8'h01) begin
         cnt     <= 8'h00;
         pulse_o <= ~pulse_o;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule // bpis_pulse_src
`default_nettype wire

// *** tb/bpis_top_tb_top.sv ***
`default_nettype none
module bpis_top_tb_top
   import bpis_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Short gate keeps the run small; all rates below are edges per gate times 100
   localparam int unsigned GATE = 1000;
   logic        clk_i;
   logic        sys_rst_i;
   logic        hsel;
   logic        hwrite;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        pulse;
   logic        sw_state;
   logic [31:0] value;
   logic        valid;
   logic        src_run;
   logic        src_lvl;
   logic [7:0]  src_half;
   int          error_cnt;
   int          cmp_count;
   logic [31:0] dexp [0:3] = '{32'h32, 32'h1f4, 32'h1388, 32'hc350};

   bpis_top #(.GATE_CYCLES(GATE), .SLOT_NO(8'h06), .INPUT_NO(8'h02)) bpis_top_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .binary_in_i(pulse), .switch_state_o(sw_state), .value_o(value),
      .value_valid_o(valid));

   bpis_pulse_src bpis_pulse_src_inst (
      .clk_i(clk_i), .run_i(src_run), .level_i(src_lvl), .half_i(src_half),
      .pulse_o(pulse));

   // Clock, 100 ns period
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Single word transfer; holds each phase until hready is sampled high
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         $display("ERROR bus wait expected 1 seen %b", hreadyout);
         test_done();
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      chk(nm, exp, d);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Main sequence
   initial begin
      int n;
      error_cnt = 0;
      cmp_count = 0;
      sys_rst_i = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0;
      hwdata = 32'h0;
      src_run = 1'b0;
      src_lvl = 1'b0;
      src_half = 8'h0a;
      wait_cyc(20);
      sys_rst_i <= 1'b0;
      // Values after reset
      rchk(32'(OFS_CTRL), CTRL_RST, "ctrl");
      rchk(32'(OFS_FMAX), 32'(FMAX_RST), "fmax");
      rchk(32'(OFS_LRV), LRV_RST, "lrv");
      rchk(32'(OFS_URV), URV_RST, "urv");
      rchk(32'(OFS_DAMP), 32'(DAMP_RST), "damp");
      rchk(32'(OFS_STAT), 32'h0002_0600, "status");
      $display("test reset done");
      // Unmapped, read-only and out-of-range accesses
      wr(32'h40, 32'h1234_5678);
      rchk(32'h40, 32'h0, "unmapped");
      wr(32'(OFS_VAL), 32'h1234_5678);
      rchk(32'(OFS_VAL), 32'h0, "value ro");
      rchk(32'h8000_0000, 32'h0, "high addr");
      wr(32'(OFS_FMAX), 32'h0);
      rchk(32'(OFS_FMAX), 32'(FMAX_MIN), "fmax low");
      wr(32'(OFS_FMAX), 32'h0020_0000);
      rchk(32'(OFS_FMAX), 32'(FMAX_MAX), "fmax high");
      wr(32'(OFS_LRV), 32'hfff0_0000);
      rchk(32'(OFS_LRV), LRV_MIN, "lrv low");
      wr(32'(OFS_URV), 32'h0100_0000);
      rchk(32'(OFS_URV), URV_MAX, "urv high");
      wr(32'(OFS_DAMP), 32'h64);
      rchk(32'(OFS_DAMP), 32'(DAMP_MAX), "damp high");
      wr(32'(OFS_TEXT), 32'h7365_7250);
      wr(32'h3c, 32'h0061_5068);
      rchk(32'(OFS_TEXT), 32'h7365_7250, "name");
      rchk(32'h3c, 32'h0061_5068, "unit");
      $display("test access done");
      // Static level, polarity and enable
      src_lvl <= 1'b1;
      wait_cyc(8);
      chk("switch", 32'h1, {31'h0, sw_state});
      wr(32'(OFS_CTRL), 32'h21);
      wait_cyc(8);
      chk("switch low act", 32'h0, {31'h0, sw_state});
      src_lvl <= 1'b0;
      wait_cyc(8);
      chk("switch low act", 32'h1, {31'h0, sw_state});
      wr(32'(OFS_CTRL), 32'h20);
      wait_cyc(8);
      chk("switch off", 32'h0, {31'h0, sw_state});
      $display("test static done");
      // Pulse mode, frequency output: 50 edges per gate, each decimal format
      wr(32'(OFS_LRV), 32'h0);
      wr(32'(OFS_URV), 32'h0);
      wr(32'(OFS_DAMP), 32'h0);
      wr(32'(OFS_FMAX), 32'h186a0);
      src_run <= 1'b1;
      for (int d = 0; d < 4; d++) begin
         wr(32'(OFS_CTRL), 32'h07 | (32'(d) << 4));
         wait_cyc(3 * GATE);
         chk("value dec", dexp[d], value);
         chk("valid", 32'h1, {31'h0, valid});
      end
      rchk(32'(OFS_FREQ), 32'h1388, "freq");
      // 125 edges per gate against a 100.00 Hz full scale
      wr(32'(OFS_FMAX), 32'h2710);
      src_half <= 8'h04;
      wr(32'(OFS_CTRL), 32'h27);
      wait_cyc(3 * GATE);
      rchk(32'(OFS_FREQ), 32'h2710, "freq clamp");
      chk("value clamp", 32'h2710, value);
      $display("test pulse done");
      // Parameter and flow scaling: -100.00 at 0 Hz, 1000.00 at 1000 Hz, input 50 Hz
      wr(32'(OFS_FMAX), 32'h186a0);
      src_half <= 8'h0a;
      wr(32'(OFS_LRV), 32'hffff_d8f0);
      wr(32'(OFS_URV), 32'h186a0);
      wr(32'(OFS_CTRL), 32'h67);
      wait_cyc(3 * GATE);
      chk("param value", 32'hffff_ee6c, value);
      for (int u = 0; u < 8; u++) begin
         wr(32'(OFS_CTRL), 32'ha7 | (32'(u) << 8));
         rchk(32'(OFS_CTRL), 32'ha7 | (32'((u == 7) ? 6 : u) << 8), "flow unit");
      end
      wr(32'(OFS_CTRL), 32'h6e7);
      rchk(32'(OFS_CTRL), 32'h6a7, "var sel");
      wait_cyc(3 * GATE);
      chk("flow value", 32'hffff_ee6c, value);
      $display("test scaling done");
      // Disable clears the value; damping of two samples starts from zeros
      wr(32'(OFS_CTRL), 32'h00);
      wr(32'(OFS_LRV), 32'h0);
      wr(32'(OFS_URV), 32'h0);
      wr(32'(OFS_DAMP), 32'h2);
      wait_cyc(4);
      chk("value off", 32'h0, value);
      chk("valid off", 32'h0, {31'h0, valid});
      wr(32'(OFS_CTRL), 32'h27);
      for (n = 0; n < 3 * GATE && valid !== 1'b1; n++) @(posedge clk_i);
      chk("valid damp", 32'h1, {31'h0, valid});
      cmp_count++;
      if ((value <= 32'h9c4 && value > 32'h0) !== 1'b1) begin
         error_cnt++;
         $display("ERROR first damped value expected 1..9c4 seen %h", value);
      end
      wait_cyc(4 * GATE);
      chk("damped steady", 32'h1388, value);
      $display("test damping done");
      test_done();
   end
endmodule // bpis_top_tb_top
`default_nettype wire
